// file: design/split_byte_timer_pkg.sv
package split_byte_timer_pkg;
  localparam int CNT_W = 8;
  localparam int NUM_CH = 4;
  localparam int PRESC_W = 4;
  localparam logic [CNT_W-1:0] CNT_TOP = 8'hff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] PERIOD_RESET = 8'hff;
  localparam logic [CNT_W-1:0] CMP_RESET = 8'h00;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 4'h0;
  localparam logic [CNT_W-1:0] PRESC_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] PRESC_ONE = 8'h01;

  typedef enum logic [1:0] {
    SRC_OFF = 2'b00,
    SRC_PER = 2'b01,
    SRC_EVT = 2'b11
  } clk_src_t;
endpackage

// file: design/byte_down_counter.sv
`timescale 1ns/10ps
// One eight-bit down-counter with four single-slope PWM channels
module byte_down_counter
  import split_byte_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic tick,
  input wire logic [CNT_W-1:0] period,
  input wire logic [NUM_CH*CNT_W-1:0] cmp,
  output logic [CNT_W-1:0] count,
  output logic underflow,
  output logic [NUM_CH-1:0] match,
  output logic [NUM_CH-1:0] pwm
);
  logic reload;

  assign reload = (count == CNT_ZERO);

  function automatic logic reaches(input logic [CNT_W-1:0] cur, input logic [CNT_W-1:0] value);
    return (cur - 8'h01) == value;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= CNT_TOP;
    end else if (!run) begin
      count <= period;
    end else if (tick) begin
      if (reload) begin
        count <= period; // RULE11
      end else begin
        count <= count - 8'h01; // RULE6
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      underflow <= 1'b0;
    end else begin
      underflow <= run && tick && reload; // RULE9
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [CNT_W-1:0] cv;
      assign cv = cmp[g*CNT_W +: CNT_W];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pwm[g] <= 1'b0;
          match[g] <= 1'b0;
        end else begin
          match[g] <= run && tick && !reload && reaches(count, cv);
          if (!run) begin
            pwm[g] <= 1'b0;
          end else if (tick && reload) begin
            pwm[g] <= (period > cv); // RULE12
          end else if (tick && reaches(count, cv)) begin
            pwm[g] <= 1'b0; // RULE12
          end
        end
      end
    end
  endgenerate

  a_count_down: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    $past(rst_n) && run && $past(run) && $past(tick) && $past(count) != CNT_ZERO |->
    count == $past(count) - 8'h01)
    else $error("counter did not decrement");
  a_reload_period: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    run && tick && reload |=> count == $past(period))
    else $error("counter did not reload period");
  a_underflow_pulse: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    underflow |-> $past(count) == CNT_ZERO && $past(tick))
    else $error("underflow without zero count");
  a_pwm_low_stop: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    !run |=> pwm == '0)
    else $error("pwm active while stopped");
  c_underflow: cover property (@(posedge clk) underflow);
  c_pwm_rise: cover property (@(posedge clk) $rose(pwm[0]));
endmodule

// file: design/split_byte_timer.sv
`timescale 1ns/10ps
// Function
// RULE1: Timer works only while the parent wide timer selects split mode.
// RULE2: Two independent eight-bit counters, low and high, four compares each.
// RULE3: Compare interrupts, events and DMA triggers come only from low byte.
// RULE4: Both counters share one clock source, separate period and compares.
// RULE5: Count clock is prescaled peripheral clock or an event input.
// RULE6: Counters only count down.
// RULE7: Waveforms are single-slope PWM only.
// RULE8: Eight PWM outputs, each duty set by its own compare value.
// RULE9: Counter underflow raises an interrupt request and an event.
// RULE10: Each low-byte compare channel gives its own interrupt and event.
// RULE11: On underflow a counter reloads its period and keeps counting down.
// RULE12: PWM goes high at reload, low when count reaches compare value.
module split_byte_timer
  import split_byte_timer_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic split_mode,
  input wire logic [1:0] clk_src,
  input wire logic [PRESC_W-1:0] presc_sel,
  input wire logic count_event,
  input wire logic [CNT_W-1:0] period_low,
  input wire logic [CNT_W-1:0] period_high,
  input wire logic [NUM_CH*CNT_W-1:0] cmp_low,
  input wire logic [NUM_CH*CNT_W-1:0] cmp_high,
  output logic [2*NUM_CH-1:0] pwm_out,
  output logic [CNT_W-1:0] count_low,
  output logic [CNT_W-1:0] count_high,
  output logic underflow_low_irq,
  output logic underflow_high_irq,
  output logic underflow_low_evt,
  output logic underflow_high_evt,
  output logic [NUM_CH-1:0] match_irq,
  output logic [NUM_CH-1:0] match_evt,
  output logic [NUM_CH-1:0] match_dma
);
  logic rst_meta;
  logic rst_n;
  logic [PRESC_W-1:0] presc_cnt;
  logic [PRESC_W-1:0] presc_lim;
  logic tick;
  logic run;
  logic [CNT_W-1:0] cnt_lo;
  logic [CNT_W-1:0] cnt_hi;
  logic uf_lo;
  logic uf_hi;
  logic [NUM_CH-1:0] m_lo;
  logic [NUM_CH-1:0] pwm_lo;
  logic [NUM_CH-1:0] pwm_hi;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Control inputs come from the same clock domain; no synchronisers
  assign run = split_mode && (clk_src != SRC_OFF); // RULE1
  assign presc_lim = presc_sel;

  // Clock source decode used only by the checks; the tick logic decodes clk_src in its own case
  function automatic logic src_sel(input logic [1:0] code, input clk_src_t want);
    return clk_src_t'(code) == want;
  endfunction

  // Prescaler divides by presc_sel+1; zero means every clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt <= PRESC_RESET;
    end else if (!run || presc_cnt == presc_lim) begin
      presc_cnt <= PRESC_RESET;
    end else begin
      presc_cnt <= presc_cnt + 4'h1;
    end
  end

  always_comb begin
    case (clk_src_t'(clk_src))
      SRC_PER: tick = (presc_cnt == presc_lim); // RULE5
      SRC_EVT: tick = count_event; // RULE5
      default: tick = 1'b0;
    endcase
  end

  // Shared tick feeds both counters // RULE4
  byte_down_counter u_low (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .tick(tick),
    .period(period_low),
    .cmp(cmp_low),
    .count(cnt_lo),
    .underflow(uf_lo),
    .match(m_lo),
    .pwm(pwm_lo)
  ); // RULE2

  byte_down_counter u_high (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .tick(tick),
    .period(period_high),
    .cmp(cmp_high),
    .count(cnt_hi),
    .underflow(uf_hi),
    .match(),
    .pwm(pwm_hi)
  ); // RULE2

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_out <= '0;
      count_low <= CNT_TOP;
      count_high <= CNT_TOP;
    end else begin
      pwm_out <= {pwm_hi, pwm_lo}; // RULE8 RULE7
      count_low <= cnt_lo;
      count_high <= cnt_hi;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      underflow_low_irq <= 1'b0;
      underflow_high_irq <= 1'b0;
      underflow_low_evt <= 1'b0;
      underflow_high_evt <= 1'b0;
    end else begin
      underflow_low_irq <= uf_lo; // RULE9
      underflow_high_irq <= uf_hi; // RULE9
      underflow_low_evt <= uf_lo;
      underflow_high_evt <= uf_hi;
    end
  end

  // High byte match is left unconnected by design
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_irq <= '0;
      match_evt <= '0;
      match_dma <= '0;
    end else begin
      match_irq <= m_lo; // RULE10 RULE3
      match_evt <= m_lo; // RULE10
      match_dma <= m_lo; // RULE3
    end
  end

  a_split_only: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    !split_mode ##1 !split_mode |=> pwm_out == '0)
    else $error("pwm output outside split mode");
  a_match_low_only: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    match_irq != '0 |-> $past(m_lo) == match_irq && match_dma == match_irq)
    else $error("match not from low byte");
  a_evt_tick: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    src_sel(clk_src, SRC_EVT) && split_mode && !count_event |-> !tick)
    else $error("tick without event");
  a_uf_to_irq: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    uf_lo |=> underflow_low_irq && underflow_low_evt)
    else $error("underflow not reported");
  a_match_events: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    m_lo[0] |=> match_irq[0] && match_evt[0])
    else $error("compare match not reported");
  a_shared_tick: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    !tick && run && $past(run) |=> $stable(cnt_lo) && $stable(cnt_hi))
    else $error("counter moved without tick");

  // Stopped timer: no pulses, counters preloaded; then checks of RULE2 to RULE5 and RULE8 to RULE10
  a_stop_no_uf: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    !run |=> !uf_lo && !uf_hi)
    else $error("underflow while stopped");
  a_stop_no_match: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    !run |=> m_lo == '0 ##1 match_irq == '0)
    else $error("compare match while stopped");
  a_stop_preload: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    !run |=> cnt_lo == $past(period_low) && cnt_hi == $past(period_high))
    else $error("stopped counter not preloaded");
  a_two_counters: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    count_low == $past(cnt_lo) && count_high == $past(cnt_hi))
    else $error("count port does not follow counter");
  a_match_from_low: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    match_irq == $past(m_lo) && match_evt == match_irq && match_dma == match_irq)
    else $error("match output not from low byte");
  a_common_tick: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    run && tick && cnt_lo != CNT_ZERO && cnt_hi != CNT_ZERO |=>
    cnt_lo == $past(cnt_lo) - 8'h01 && cnt_hi == $past(cnt_hi) - 8'h01)
    else $error("counters did not step together");
  a_presc_wait: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    src_sel(clk_src, SRC_PER) && presc_cnt != presc_lim |-> !tick)
    else $error("tick before prescaler wrap");
  a_presc_wrap: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    presc_cnt == presc_lim |=> presc_cnt == PRESC_RESET)
    else $error("prescaler did not wrap");
  a_evt_counts: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    src_sel(clk_src, SRC_EVT) && count_event |-> tick)
    else $error("event did not give a tick");
  a_off_no_tick: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    !src_sel(clk_src, SRC_PER) && !src_sel(clk_src, SRC_EVT) |-> !tick)
    else $error("tick with no clock source");
  a_pwm_follows: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    pwm_out[NUM_CH-1:0] == $past(pwm_lo) &&
    pwm_out[2*NUM_CH-1:NUM_CH] == $past(pwm_hi))
    else $error("pwm output does not follow channels");
  a_uf_high_report: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    uf_hi |=> underflow_high_irq && underflow_high_evt)
    else $error("high underflow not reported");
  a_uf_exact: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    underflow_low_irq == $past(uf_lo) && underflow_high_irq == $past(uf_hi) &&
    underflow_low_evt == underflow_low_irq && underflow_high_evt == underflow_high_irq)
    else $error("underflow output without underflow");
  a_match_channels: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    m_lo[NUM_CH-1] |=> match_irq[NUM_CH-1] && match_evt[NUM_CH-1])
    else $error("last compare match not reported");

  c_low_uf: cover property (@(posedge clk) underflow_low_irq);
  c_match: cover property (@(posedge clk) match_irq[1]);
  c_evt_src: cover property (@(posedge clk) src_sel(clk_src, SRC_EVT) && tick);
endmodule

// file: sim/tb.sv
`timescale 1ns/10ps
module tb
  import split_byte_timer_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic split_mode = 1'b0;
  logic [1:0] clk_src = 2'h0;
  logic [PRESC_W-1:0] presc_sel = 4'h0;
  logic count_event = 1'b0;
  logic [CNT_W-1:0] period_low = 8'h03;
  logic [CNT_W-1:0] period_high = 8'h05;
  logic [NUM_CH*CNT_W-1:0] cmp_low = 32'h01020100;
  logic [NUM_CH*CNT_W-1:0] cmp_high = 32'h04030201;
  logic [2*NUM_CH-1:0] pwm_out;
  logic [CNT_W-1:0] count_low, count_high;
  logic underflow_low_irq, underflow_high_irq, underflow_low_evt, underflow_high_evt;
  logic [NUM_CH-1:0] match_irq, match_evt, match_dma;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int u_lo, u_hi;
  int mi[4];
  int pw[8];

  split_byte_timer split_byte_timer_i (.clk(clk), .reset_n(reset_n), .split_mode(split_mode),
    .clk_src(clk_src), .presc_sel(presc_sel), .count_event(count_event),
    .period_low(period_low), .period_high(period_high), .cmp_low(cmp_low),
    .cmp_high(cmp_high), .pwm_out(pwm_out), .count_low(count_low), .count_high(count_high),
    .underflow_low_irq(underflow_low_irq), .underflow_high_irq(underflow_high_irq),
    .underflow_low_evt(underflow_low_evt), .underflow_high_evt(underflow_high_evt),
    .match_irq(match_irq), .match_evt(match_evt), .match_dma(match_dma));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic conclude();
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hung scenarios end here instead of running on
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Event pulse every ep cycles; each-cycle sequence checked only when ep is 1
  task automatic window(input int n, input int ep);
    logic [7:0] pl, ph;
    logic [9:0] sent, got;
    u_lo = 0;
    u_hi = 0;
    foreach (mi[c]) mi[c] = 0;
    foreach (pw[c]) pw[c] = 0;
    pl = count_low;
    ph = count_high;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      #2 count_event = (ep > 0) && (k % ep == 0);
      @(negedge clk);
      u_lo += int'(underflow_low_irq);
      u_hi += int'(underflow_high_irq);
      foreach (mi[c]) mi[c] += int'(match_irq[c]);
      foreach (pw[c]) pw[c] += int'(pwm_out[c]);
      sent = {underflow_low_irq, underflow_high_irq, match_irq, match_irq};
      got = {underflow_low_evt, underflow_high_evt, match_evt, match_dma};
      check("evt_dma", 32'(sent), 32'(got));
      if (ep == 1) begin
        check("count_low", pl == 8'h00 ? period_low : 8'(pl - 8'h01), count_low);
        check("count_high", ph == 8'h00 ? period_high : 8'(ph - 8'h01), count_high);
      end
      pl = count_low;
      ph = count_high;
    end
  endtask

  task automatic t_stopped();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      #2 split_mode = (i != 0);
      clk_src = (i == 0) ? 2'h1 : {i == 2, 1'b0};
      window(20, 2);
      check("held_low", period_low, count_low);
      check("held_high", period_high, count_high);
      check("held_pwm", 8'h00, pwm_out);
      check("held_pulses", 0, u_lo + u_hi + mi[0] + mi[1] + mi[2] + mi[3]);
    end
  endtask

  task automatic t_pwm();
    int cv;
    @(posedge clk);
    #2 split_mode = 1'b1;
    clk_src = SRC_PER;
    presc_sel = 4'h0;
    window(20, 0);
    window(48, 1);
    check("underflows", {16'(u_lo), 16'(u_hi)}, {16'd12, 16'd8});
    foreach (mi[c]) check("match", 12, mi[c]);
    foreach (pw[c]) begin
      cv = (c < 4) ? int'(cmp_low[8 * c +: 8]) : int'(cmp_high[8 * (c - 4) +: 8]);
      check("duty", (c < 4) ? 12 * (3 - cv) : 8 * (5 - cv), pw[c]);
    end
  endtask

  task automatic t_source();
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      #2 clk_src = s ? SRC_EVT : SRC_PER;
      presc_sel = s ? 4'h0 : 4'h2;
      window(20, 3);
      window(72, 3);
      check("src_underflows", {16'(u_lo), 16'(u_hi)}, {16'd6, 16'd4});
      check("src_match", 6, mi[1]);
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #2 reset_n = 1'b1;
    repeat (3) @(posedge clk);
    t_stopped();
    t_pwm();
    t_source();
    conclude();
  end
endmodule
